/* File: shared/delay_code_pkg.sv */
// constants, types and helpers for the delay code controller
package delay_code_pkg;
    localparam logic [6:0]  I2C_BASE     = 7'h38;
    localparam logic [1:0]  SEL_RED      = 2'h0;
    localparam logic [1:0]  SEL_GREEN    = 2'h1;
    localparam logic [1:0]  SEL_BLUE     = 2'h2;
    localparam logic [1:0]  SEL_NONE     = 2'h3;
    localparam logic [15:0] STEP_PS      = 16'h0320;
    localparam logic [3:0]  SPI_CMD_LAST = 4'h7;
    localparam logic [3:0]  SPI_LAST     = 4'hf;
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [1:0]  BYTE_DATA    = 2'h2;

    typedef logic [5:0] code_t;

    typedef struct packed {
        code_t red;
        code_t green;
        code_t blue;
    } codes_t;

    typedef struct packed {
        logic [15:0] red;
        logic [15:0] green;
        logic [15:0] blue;
    } delay_ps_t;

    // pins seen by the core clock, synchronised as a group
    typedef struct packed {
        logic   awake;
        logic   analog;
        logic   spi;
        logic   scl;
        logic   sda;
        logic   a1;
        logic   a0;
        logic   tog;
        codes_t adc;
    } pins_t;

    typedef enum logic [2:0] {
        I_IDLE, I_RX, I_ACK, I_TX, I_MACK
    } i2c_st_t;

    function automatic code_t sel_code(input codes_t c,
                                       input logic [1:0] sel);
        code_t r;
        r = 6'h00;
        unique case (sel)
            SEL_RED:   r = c.red;
            SEL_GREEN: r = c.green;
            SEL_BLUE:  r = c.blue;
            SEL_NONE:  r = 6'h00;
        endcase
        return r;
    endfunction : sel_code

    function automatic logic [15:0] code_ps(input code_t c);
        return {10'h000, c} * STEP_PS;
    endfunction : code_ps
endpackage : delay_code_pkg

/* File: verilog/triple_delay_code_control.sv */
// delay code bank with spi, i2c and analog control sources
//
// Notes on behaviour
// [RULE1] sleep strap low forces power-down whatever the other straps say.
// [RULE2] power-down saves power but video outputs stay driven.
// [RULE3] analog strap high takes all codes from control voltages.
// [RULE4] digital mode: bus strap high selects spi, low selects i2c.
// [RULE5] red, green and blue each keep an independent code.
// [RULE6] codes are unsigned 0 to 63, one delay step each.
// [RULE7] channel delay equals code times a 0.8 ns step.
// [RULE8] code zero means only the common fixed propagation delay.
// [RULE9] analog voltages are digitised to codes of the same step.
// [RULE10] one control source serves all three channels together.
// [RULE11] commands carry read/write bit and 2-bit colour select.
// [RULE12] host should zero the slowest channel and delay the others.
// [RULE13] spi frame: header byte, then data byte, which carries the selected code out on reads.
// [RULE14] spi bits move on rising clock edge, msb first, select low.
// [RULE15] i2c address is fixed base plus two address straps.
// [RULE16] i2c write is three bytes, read is four bytes.
// [RULE17] colour select 11 writes nothing and reads as zero.
`timescale 1ns/10ps
module triple_delay_code_control (
    // core clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     rst,
    // serial clock pin, spi sck or i2c scl
    input  wire logic                     serial_clk,
    // shared serial pins
    input  wire logic                     csn_addr_strap_lo,
    input  wire logic                     sdi_addr_strap_hi,
    input  wire logic                     sdo_sda_i,
    output logic                          sdo_sda_o,
    output logic                          sdo_sda_oe,
    // straps
    input  wire logic                     sleep_strap,
    input  wire logic                     analog_mode_strap,
    input  wire logic                     bus_choice_strap,
    // digitised control voltages
    input  wire delay_code_pkg::code_t    red_ctrl_voltage,
    input  wire delay_code_pkg::code_t    green_ctrl_voltage,
    input  wire delay_code_pkg::code_t    blue_ctrl_voltage,
    // to the delay path
    output delay_code_pkg::codes_t        delay_codes,
    output delay_code_pkg::delay_ps_t     delay_ps,
    output logic                          sleep,
    output logic                          video_drive
);
    typedef struct packed {
        delay_code_pkg::pins_t     p1;
        delay_code_pkg::pins_t     p2;
        logic                      scl_d;
        logic                      sda_d;
        logic                      tog_d;
        logic                      i2c_on;
        logic                      spi_on;
        delay_code_pkg::codes_t    codes;
        delay_code_pkg::delay_ps_t ps;
        logic                      sleep;
        logic                      video;
        logic                      oe;
        logic                      pin_oe;
        delay_code_pkg::i2c_st_t   ist;
        logic [3:0]                bcnt;
        logic [7:0]                sh;
        logic [1:0]                byte_n;
        logic [1:0]                sel;
        logic                      rd;
    } core_t;

    // link side, cleared whenever select is high
    typedef struct packed {
        logic [3:0] cnt;
        logic [7:0] cmd;
        logic [7:0] hdr;
        logic [7:0] out;
        logic       sdo;
    } link_t;

    // link side state that must outlive a frame
    typedef struct packed {
        logic                   tog;
        logic [7:0]             word;
        logic                   m1;
        logic                   m2;
        delay_code_pkg::codes_t k1;
        delay_code_pkg::codes_t k2;
    } hold_t;

    core_t                  c;
    core_t                  n;
    link_t                  lk;
    link_t                  ln;
    hold_t                  h;
    hold_t                  hn;
    delay_code_pkg::pins_t  pins_now;
    logic                   rise;
    logic                   fall;
    logic                   start;
    logic                   stop;
    logic                   addr_hit;
    logic                   wr;
    logic [1:0]             wsel;
    delay_code_pkg::code_t  wcode;
    logic                   spi_ok;

    assign pins_now = '{awake: sleep_strap, analog: analog_mode_strap,
                        spi: bus_choice_strap, scl: serial_clk,
                        sda: sdo_sda_i, a1: sdi_addr_strap_hi,
                        a0: csn_addr_strap_lo, tog: h.tog,
                        adc: '{red: red_ctrl_voltage,
                               green: green_ctrl_voltage,
                               blue: blue_ctrl_voltage}};
    assign rise  = c.p2.scl & ~c.scl_d;
    assign fall  = ~c.p2.scl & c.scl_d;
    assign start = c.p2.scl & c.scl_d & ~c.p2.sda & c.sda_d;
    assign stop  = c.p2.scl & c.scl_d & c.p2.sda & ~c.sda_d;
    assign addr_hit = c.sh[7:1] ==
        {delay_code_pkg::I2C_BASE[6:2], c.p2.a1, c.p2.a0}; // RULE15
    // header byte must carry five zero bits and ask for a write
    assign spi_ok = ~lk.hdr[7] & (lk.hdr[6:2] == 5'h00);

    always_comb begin
        delay_code_pkg::code_t tx;
        tx = 6'h00;
        n = c;
        wr = 1'b0;
        wsel = c.sel;
        wcode = c.sh[5:0];
        n.p1 = pins_now;
        n.p2 = c.p1;
        n.scl_d = c.p2.scl;
        n.sda_d = c.p2.sda;
        n.tog_d = c.p2.tog;
        n.video = 1'b1; // RULE2
        n.sleep = ~c.p2.awake; // RULE1
        n.i2c_on = c.p2.awake & ~c.p2.analog & ~c.p2.spi; // RULE4
        n.spi_on = c.p2.awake & ~c.p2.analog & c.p2.spi; // RULE4
        if (!c.i2c_on) begin
            n.ist = delay_code_pkg::I_IDLE;
            n.oe = 1'b0;
        end else if (start) begin
            n.ist = delay_code_pkg::I_RX;
            n.bcnt = 4'h0;
            n.byte_n = 2'h0;
            n.oe = 1'b0;
        end else if (stop) begin
            n.ist = delay_code_pkg::I_IDLE;
            n.oe = 1'b0;
        end else begin
            unique case (c.ist)
                delay_code_pkg::I_IDLE: begin
                end
                delay_code_pkg::I_RX: begin
                    if (rise) begin
                        n.sh = {c.sh[6:0], c.p2.sda};
                        n.bcnt = c.bcnt + 4'h1;
                    end else if (fall && c.bcnt == delay_code_pkg::BYTE_BITS) begin
                        n.ist = delay_code_pkg::I_ACK;
                        n.oe = 1'b1;
                        unique case (c.byte_n) // RULE16
                            2'h0: begin
                                n.rd = c.sh[0]; // RULE11
                                if (!addr_hit) begin // RULE15
                                    n.ist = delay_code_pkg::I_IDLE;
                                    n.oe = 1'b0;
                                end
                            end
                            2'h1: n.sel = c.sh[1:0]; // RULE11
                            default: wr = 1'b1; // RULE16
                        endcase
                    end
                end
                delay_code_pkg::I_ACK: begin
                    if (fall) begin
                        n.bcnt = 4'h0;
                        if (c.byte_n != delay_code_pkg::BYTE_DATA) begin
                            n.byte_n = c.byte_n + 2'h1;
                        end
                        if (c.rd) begin
                            tx = delay_code_pkg::sel_code(c.codes, c.sel); // RULE17
                            n.sh = {2'h0, tx};
                            n.oe = 1'b1;
                            n.ist = delay_code_pkg::I_TX;
                        end else begin
                            n.oe = 1'b0;
                            n.ist = delay_code_pkg::I_RX;
                        end
                    end
                end
                delay_code_pkg::I_TX: begin
                    if (rise) begin
                        n.bcnt = c.bcnt + 4'h1;
                    end else if (fall) begin
                        if (c.bcnt == delay_code_pkg::BYTE_BITS) begin
                            n.oe = 1'b0;
                            n.ist = delay_code_pkg::I_MACK;
                        end else begin
                            n.sh = {c.sh[6:0], 1'b0};
                            n.oe = ~c.sh[6];
                        end
                    end
                end
                delay_code_pkg::I_MACK: begin
                    if (rise) begin
                        n.ist = delay_code_pkg::I_IDLE;
                    end
                end
            endcase
        end
        // pin enable registered so the output comes straight from a flop
        n.pin_oe = n.oe | n.spi_on & ~n.p2.a0;
        // toggle is seen only after the word has settled
        if (c.spi_on && c.p2.tog != c.tog_d) begin
            wr = 1'b1;
            wsel = h.word[7:6];
            wcode = h.word[5:0];
        end
        if (!c.p2.awake) begin
            n.codes = c.codes; // RULE1
        end else if (c.p2.analog) begin
            n.codes = c.p2.adc; // RULE3 RULE9 RULE10
        end else if (wr) begin
            unique case (wsel) // RULE5 RULE10
                delay_code_pkg::SEL_RED:   n.codes.red = wcode;
                delay_code_pkg::SEL_GREEN: n.codes.green = wcode;
                delay_code_pkg::SEL_BLUE:  n.codes.blue = wcode;
                delay_code_pkg::SEL_NONE:  n.codes = c.codes; // RULE17
            endcase
        end
        n.ps.red = delay_code_pkg::code_ps(c.codes.red); // RULE7 RULE8
        n.ps.green = delay_code_pkg::code_ps(c.codes.green); // RULE7
        n.ps.blue = delay_code_pkg::code_ps(c.codes.blue); // RULE6
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end

    always_comb begin
        logic [7:0] rd_val;
        rd_val = 8'h00;
        ln = lk;
        ln.cnt = lk.cnt + 4'h1;
        ln.cmd = {lk.cmd[6:0], sdi_addr_strap_hi}; // RULE14
        ln.sdo = lk.out[7] & h.m2;
        ln.out = {lk.out[6:0], 1'b0};
        if (lk.cnt == delay_code_pkg::SPI_CMD_LAST) begin
            ln.hdr = ln.cmd;
            if (ln.cmd[7]) begin
                rd_val = {2'h0, delay_code_pkg::sel_code(h.k2,
                                                         ln.cmd[1:0])}; // RULE13
            end
            ln.sdo = rd_val[7] & h.m2;
            ln.out = {rd_val[6:0], 1'b0};
        end
    end

    // frame logic clears on select high, so a cut frame writes nothing
    always_ff @(posedge serial_clk or posedge rst
                or posedge csn_addr_strap_lo) begin
        if (rst || csn_addr_strap_lo) begin
            lk <= '0;
        end else begin
            lk <= ln;
        end
    end

    // codes cross as a quasi-static level; they only move between frames
    always_comb begin
        hn = h;
        hn.m1 = c.spi_on;
        hn.m2 = h.m1;
        hn.k1 = c.codes;
        hn.k2 = h.k1;
        if (lk.cnt == delay_code_pkg::SPI_LAST && spi_ok && h.m2) begin
            hn.word = {lk.hdr[1:0], lk.cmd[4:0], sdi_addr_strap_hi}; // RULE13
            hn.tog = ~h.tog;
        end
    end

    always_ff @(posedge serial_clk or posedge rst) begin
        if (rst) begin
            h <= '0;
        end else begin
            h <= hn;
        end
    end

    assign sdo_sda_o   = lk.sdo;
    assign sdo_sda_oe  = c.pin_oe;
    assign delay_codes = c.codes;
    assign delay_ps    = c.ps;
    assign sleep       = c.sleep;
    assign video_drive = c.video;
    sequence s_addr_byte;
        c.ist == delay_code_pkg::I_RX && fall && c.i2c_on && !start &&
        !stop && c.bcnt == delay_code_pkg::BYTE_BITS && c.byte_n == 2'h0;
    endsequence

    a_sleep_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE1
        !c.p2.awake |=> $stable(c.codes) && sleep)
        else $error("codes moved in power-down");
    a_video_on: assert property (@(posedge core_clk) disable iff (rst) // RULE2
        !c.p2.awake ##1 1'b1 |-> video_drive)
        else $error("video drive dropped");
    a_analog_track: assert property (@(posedge core_clk) disable iff (rst) // RULE3
        c.p2.awake && c.p2.analog |=> c.codes == $past(c.p2.adc))
        else $error("analog code not taken");
    a_i2c_quiet: assert property (@(posedge core_clk) disable iff (rst) // RULE4
        (c.p2.spi && c.p2.awake) [*2] |=> !c.oe)
        else $error("i2c drives in spi mode");
    a_step_ps: assert property (@(posedge core_clk) disable iff (rst) // RULE7
        1'b1 |=> delay_ps.red == {10'h000, $past(c.codes.red)} *
                 delay_code_pkg::STEP_PS)
        else $error("delay not code times step");
    a_zero_base: assert property (@(posedge core_clk) disable iff (rst) // RULE8
        c.codes.green == 6'h00 |=> delay_ps.green == 16'h0000)
        else $error("zero code adds delay");
    a_addr_ack: assert property (@(posedge core_clk) disable iff (rst) // RULE15
        s_addr_byte and addr_hit |=> c.oe &&
        c.ist == delay_code_pkg::I_ACK)
        else $error("own address not acknowledged");
    a_sel3_noop: assert property (@(posedge core_clk) disable iff (rst) // RULE17
        wr && wsel == delay_code_pkg::SEL_NONE && c.p2.awake &&
        !c.p2.analog |=> $stable(c.codes))
        else $error("select 11 changed a code");
    a_spi_count: assert property (@(posedge serial_clk) // RULE14
        disable iff (rst || csn_addr_strap_lo)
        lk.cnt != delay_code_pkg::SPI_LAST |=> lk.cnt == $past(lk.cnt) + 4'h1)
        else $error("spi bit count skipped");
    a_spi_write: assert property (@(posedge serial_clk) // RULE13
        disable iff (rst || csn_addr_strap_lo)
        lk.cnt == delay_code_pkg::SPI_LAST && spi_ok && h.m2
        |=> h.tog != $past(h.tog))
        else $error("spi write not handed over");
endmodule : triple_delay_code_control

/* File: bench/host_model.sv */
// host model: spi and i2c master for the delay code bank
`timescale 1ns/10ps
module host_model (
    // serial clock and the two shared select pins
    output logic      sck,
    output logic      csn,
    output logic      sdi,
    // open drain pull on the data wire, and its level
    output logic      pull_low,
    input  wire logic line
);
    localparam int HALF = 16;

    initial begin
        sck      = 1'b0;
        csn      = 1'b1;
        sdi      = 1'b0;
        pull_low = 1'b0;
    end

    // one clock pulse while reset is held
    task automatic tick();
        #HALF;
        sck = 1'b1;
        #HALF;
        sck = 1'b0;
    endtask : tick

    // two-byte frame; clock stands still outside it
    task automatic spi_frame(input logic [7:0] hdr, input logic [7:0] dat,
                             output logic [7:0] rd);
        logic [15:0] sh;
        sh  = {hdr, dat};
        rd  = 8'h00;
        sck = 1'b0;
        csn = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = sh[i];
            #HALF;
            if (i < 8)
                rd = {rd[6:0], line};
            sck = 1'b1;
            #HALF;
            sck = 1'b0;
        end
        sdi = ~sdi; // flipped: the last bit is not left standing on the wire
        #HALF;
        csn = 1'b1;
        #(3 * HALF); // gap lets the core apply the write
    endtask : spi_frame

    // straps share the spi select pins; scl idles high
    task automatic i2c_pins(input logic a1, input logic a0);
        csn = a0;
        sdi = a1;
        sck = 1'b1;
        #(4 * HALF);
    endtask : i2c_pins

    // start, or repeated start from a low clock
    task automatic i2c_start(input logic again);
        if (again) begin
            pull_low = 1'b0;
            #HALF; // device must let go of its ack first
            sck = 1'b1;
            #HALF;
        end
        pull_low = 1'b1;
        #HALF;
        sck = 1'b0;
    endtask : i2c_start

    task automatic i2c_stop();
        pull_low = 1'b1;
        #(HALF / 2);
        sck = 1'b1;
        #HALF;
        pull_low = 1'b0;
        #HALF;
    endtask : i2c_stop

    // eight bits and a ninth; a one releases the wire
    task automatic i2c_byte(input logic [7:0] b, output logic [7:0] rd,
                            output logic ack);
        logic [8:0] sh;
        sh = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            #(HALF / 2);
            pull_low = ~sh[i];
            #(HALF / 2);
            sck = 1'b1;
            if (i > 0)
                rd = {rd[6:0], line};
            else
                ack = ~line;
            #HALF;
            sck = 1'b0;
        end
    endtask : i2c_byte

    task automatic i2c_write(input logic [6:0] a, input logic [7:0] r,
                             input logic [7:0] d, output logic ok);
        logic [7:0] x;
        logic       k0, k1, k2;
        i2c_start(1'b0);
        i2c_byte({a, 1'b0}, x, k0);
        i2c_byte(r, x, k1);
        i2c_byte(d, x, k2);
        i2c_stop();
        ok = k0 & k1 & k2;
    endtask : i2c_write

    task automatic i2c_read(input logic [6:0] a, input logic [7:0] r,
                            output logic [7:0] d);
        logic [7:0] x;
        logic       k;
        i2c_start(1'b0);
        i2c_byte({a, 1'b0}, x, k);
        i2c_byte(r, x, k);
        i2c_start(1'b1);
        i2c_byte({a, 1'b1}, x, k);
        i2c_byte(8'hff, d, k); // master nack ends the read
        i2c_stop();
    endtask : i2c_read
endmodule : host_model

/* File: bench/tb_top.sv */
// self-checking bench for the delay code bank
`timescale 1ns/10ps
module tb_top;
    logic                      core_clk, rst;
    logic                      sck, csn, sdi, pull_low, sdo_o, sdo_oe;
    wire logic                 line;
    logic                      sleep_strap, analog_strap, bus_strap;
    delay_code_pkg::codes_t    volts, delay_codes;
    delay_code_pkg::delay_ps_t delay_ps;
    logic                      sleep, video_drive, ok;
    logic [7:0]                rd;
    logic [1:0]                asel;
    logic [6:0]                adr;
    int                        n_mismatch, check_count;

    // wired-and with pull-up: nobody driving reads high
    assign line = ~pull_low & (~sdo_oe | sdo_o);

    always #2 core_clk = ~core_clk;

    triple_delay_code_control triple_delay_code_control_inst (
        .core_clk          (core_clk),
        .rst               (rst),
        .serial_clk        (sck),
        .csn_addr_strap_lo (csn),
        .sdi_addr_strap_hi (sdi),
        .sdo_sda_i         (line),
        .sdo_sda_o         (sdo_o),
        .sdo_sda_oe        (sdo_oe),
        .sleep_strap       (sleep_strap),
        .analog_mode_strap (analog_strap),
        .bus_choice_strap  (bus_strap),
        .red_ctrl_voltage  (volts.red),
        .green_ctrl_voltage(volts.green),
        .blue_ctrl_voltage (volts.blue),
        .delay_codes       (delay_codes),
        .delay_ps          (delay_ps),
        .sleep             (sleep),
        .video_drive       (video_drive)
    );

    host_model host_model_inst (
        .sck     (sck),
        .csn     (csn),
        .sdi     (sdi),
        .pull_low(pull_low),
        .line    (line)
    );

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_val

    // codes and their delay in ps, step of 800 ps
    task automatic cmp_codes(input delay_code_pkg::codes_t exp);
        repeat (6) @(negedge core_clk);
        cmp_val({10'h000, delay_codes.red}, {10'h000, exp.red});
        cmp_val({10'h000, delay_codes.green}, {10'h000, exp.green});
        cmp_val({10'h000, delay_codes.blue}, {10'h000, exp.blue});
        cmp_val(delay_ps.red, {10'h000, exp.red} * 16'h0320);
        cmp_val(delay_ps.green, {10'h000, exp.green} * 16'h0320);
        cmp_val(delay_ps.blue, {10'h000, exp.blue} * 16'h0320);
    endtask : cmp_codes

    task automatic set_mode(input logic sl, input logic an, input logic bu);
        @(negedge core_clk);
        sleep_strap  = sl;
        analog_strap = an;
        bus_strap    = bu;
        repeat (8) @(negedge core_clk);
    endtask : set_mode

    task automatic spi_wr(input logic [1:0] sel, input logic [7:0] d);
        host_model_inst.spi_frame({6'h00, sel}, d, rd);
        repeat (8) @(negedge core_clk);
    endtask : spi_wr

    task automatic spi_rd(input logic [1:0] sel, input logic [5:0] exp);
        host_model_inst.spi_frame({1'b1, 5'h00, sel}, 8'h00, rd);
        cmp_val({8'h00, rd}, {10'h000, exp});
    endtask : spi_rd

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // a full run takes about 15 us
    initial begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        core_clk     = 1'b0;
        rst          = 1'b1;
        n_mismatch   = 0;
        check_count  = 0;
        sleep_strap  = 1'b1;
        analog_strap = 1'b0;
        bus_strap    = 1'b1;
        volts        = {6'h07, 6'h09, 6'h0b};
        fork
            host_model_inst.tick();
            repeat (12) @(negedge core_clk);
        join
        rst = 1'b0;
        cmp_codes({6'h00, 6'h00, 6'h00});
        cmp_val({15'h0000, video_drive}, 16'h0001);
        cmp_val({15'h0000, sleep}, 16'h0000);
        // spi: slowest path zero, others padded
        host_model_inst.spi_frame(8'h83, 8'h00, rd);
        spi_wr(delay_code_pkg::SEL_RED, 8'h32);
        spi_wr(delay_code_pkg::SEL_GREEN, 8'hc0);
        spi_wr(delay_code_pkg::SEL_BLUE, 8'h23);
        cmp_codes({6'h32, 6'h00, 6'h23});
        spi_rd(delay_code_pkg::SEL_BLUE, 6'h23);
        spi_wr(delay_code_pkg::SEL_NONE, 8'h15);
        spi_rd(delay_code_pkg::SEL_NONE, 6'h00);
        // a read header and a header with a stray bit both write nothing
        host_model_inst.spi_frame(8'h80, 8'h04, rd);
        host_model_inst.spi_frame(8'h04, 8'h11, rd);
        cmp_codes({6'h32, 6'h00, 6'h23});
        spi_wr(delay_code_pkg::SEL_GREEN, 8'h3f);
        spi_rd(delay_code_pkg::SEL_GREEN, 6'h3f);
        $display("test spi done");
        // i2c: every strap address, then a near miss
        set_mode(1'b1, 1'b0, 1'b0);
        for (int a = 0; a < 4; a++) begin
            asel = 2'(a);
            adr  = delay_code_pkg::I2C_BASE | {5'h00, asel};
            host_model_inst.i2c_pins(asel[1], asel[0]);
            host_model_inst.i2c_write(adr, 8'h02, {6'h00, asel} + 8'h01, ok);
            cmp_val({15'h0000, ok}, 16'h0001);
        end
        host_model_inst.i2c_write(delay_code_pkg::I2C_BASE, 8'h00, 8'h01, ok);
        cmp_val({15'h0000, ok}, 16'h0000);
        host_model_inst.i2c_write(adr, 8'h01, 8'h15, ok);
        host_model_inst.i2c_read(adr, 8'h00, rd);
        cmp_val({8'h00, rd}, 16'h0032);
        cmp_codes({6'h32, 6'h15, 6'h04});
        $display("test i2c done");
        // analog: voltages win, bus strap and spi ignored
        set_mode(1'b1, 1'b1, 1'b1);
        cmp_codes({6'h07, 6'h09, 6'h0b});
        spi_wr(delay_code_pkg::SEL_RED, 8'h01);
        @(negedge core_clk);
        volts = {6'h3f, 6'h00, 6'h21};
        cmp_codes({6'h3f, 6'h00, 6'h21});
        $display("test analog done");
        // power-down overrides every other strap
        set_mode(1'b0, 1'b1, 1'b1);
        cmp_val({15'h0000, sleep}, 16'h0001);
        cmp_val({15'h0000, video_drive}, 16'h0001);
        set_mode(1'b0, 1'b0, 1'b0);
        cmp_val({15'h0000, sleep}, 16'h0001);
        $display("test sleep done");
        end_of_test();
    end
endmodule : tb_top
